// *** uis_host_model.sv ***
`default_nettype none
// ----------------------------------------------------------------
// cpu side of the register port: one-cycle strobes, no waits
// ----------------------------------------------------------------
module uis_host_model (
  // clock
  input wire logic ref_clk,
  // register port towards the device
  output var logic [uis_pkg::ADDR_W-1:0] regAddr,
  output var logic [uis_pkg::DATA_W-1:0] regWdata,
  output var logic regWr,
  output var logic regRd,
  input wire logic [uis_pkg::DATA_W-1:0] regRdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    regAddr = '0;
    regWdata = '0;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // one write cycle; a zero clears only the bits it is meant
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    // data no longer held: show the inverse so a stale value cannot pass
    regWdata <= ~d;
  endtask

  // one read cycle, data taken in the cycle after the strobe only
  // sampled at the closing edge, so callers stay on clock edges
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    d = regRdata;
  endtask
endmodule
`default_nettype wire

// *** uis_pkg.sv ***
`default_nettype none
// ----------------------------------------------------------------
// shared constants and carriers for the usb interrupt status block
// ----------------------------------------------------------------
package uis_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_EMPTY_EN = 8'h4C; // buffer_empty_irq_enable
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h60;   // main_interrupt_status

  // pipe count: control pipe at bit 0, pipes 1..6 above it
  localparam int PIPE_CNT = 7;

  // reset values and masks
  localparam logic [DATA_W-1:0] EMPTY_EN_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] EMPTY_EN_MASK = 16'h007F;
  localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

  // device state codes, low two bits free while suspended
  localparam logic [2:0] DEV_POWERED = 3'h0;
  localparam logic [2:0] DEV_DEFAULT = 3'h1;
  localparam logic [2:0] DEV_ADDRESS = 3'h2;
  localparam logic [2:0] DEV_CONFIGURED = 3'h3;
  localparam logic [2:0] DEV_SUSPENDED = 3'h4;

  // control transfer stage codes
  localparam logic [2:0] STG_IDLE = 3'h0;
  localparam logic [2:0] STG_RD_DATA = 3'h1;
  localparam logic [2:0] STG_RD_STATUS = 3'h2;
  localparam logic [2:0] STG_WR_DATA = 3'h3;
  localparam logic [2:0] STG_WR_STATUS = 3'h4;
  localparam logic [2:0] STG_WR_NODATA = 3'h5;
  localparam logic [2:0] STG_SEQ_ERROR = 3'h6;

  // main status word, field order is the bit layout (msb first)
  typedef struct packed {
    logic vbusChange;      // bit 15
    logic resume;          // bit 14
    logic rsv13;           // bit 13, reads zero
    logic devStateChange;  // bit 12
    logic ctrlStageChange; // bit 11
    logic bufEmpty;        // bit 10
    logic bufNotReady;     // bit 9
    logic bufReady;        // bit 8
    logic vbusLevel;       // bit 7
    logic [2:0] devState;  // bits 6..4
    logic setupSeen;       // bit 3
    logic [2:0] ctrlStage; // bits 2..0
  } uis_stat_t;

  // events from the protocol engine, all one-cycle pulses
  typedef struct packed {
    logic swReset;         // software reset
    logic busReset;        // usb bus reset detected
    logic resumeEvt;       // resume signalling seen
    logic devStateEvt;     // device state moved
    logic [2:0] devStateNew;
    logic ctrlStageEvt;    // control stage moved
    logic [2:0] ctrlStageNew;
    logic setupEvt;        // setup packet fully received
  } uis_evt_t;

endpackage
`default_nettype wire

// *** uis_status_top.sv ***
`default_nettype none
module uis_status_top #(
  parameter int PIPES = uis_pkg::PIPE_CNT
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [uis_pkg::ADDR_W-1:0] regAddr,
  input wire logic [uis_pkg::DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output var logic [uis_pkg::DATA_W-1:0] regRdata,
  // vbus pin, asynchronous
  input wire logic vbusPin,
  // internal clock supply indication, same domain
  input wire logic intClockOn,
  // protocol engine events
  input wire uis_pkg::uis_evt_t evt,
  // per-pipe empty/size-error flags, bit 0 is the control pipe
  input wire logic [PIPES-1:0] pipeEmptyFlags,
  // already-enabled summary requests from the other flag registers
  input wire logic bufNotReadyReq,
  input wire logic bufReadyReq,
  // status towards the rest of the core
  output var logic setupPending,
  output var logic [2:0] deviceState,
  output var logic [2:0] ctrlStage
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [PIPES-1:0] emptyIrqEn;     // pipeN_empty_irq_en bits
  logic [PIPES-1:0] prevEmptyFlags; // last cycle's pipe flags
  logic vbusLevel;                  // filtered pin level
  logic vbusLevelPrev;              // for edge detection
  logic vbusChangeFlag;             // sticky bit 15
  logic resumeFlag;                 // sticky bit 14
  logic vbusHold;                   // clear held while clock stopped
  logic resumeHold;                 // clear held while clock stopped
  logic devStateChangeFlag;         // sticky bit 12
  logic ctrlStageChangeFlag;        // sticky bit 11
  logic bufEmptySummary;            // bit 10
  logic bufNotReadySummary;         // bit 9
  logic bufReadySummary;            // bit 8

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  uis_pkg::uis_stat_t wrWord;  // write data seen as status layout
  uis_pkg::uis_stat_t statNow; // current status word
  logic wrEn;                  // write to enable register
  logic wrStat;                // write to status register
  logic vbusEdge;              // either direction
  logic [PIPES-1:0] emptyRise; // enabled flags that just rose
  logic [uis_pkg::DATA_W-1:0] enWord;

  assign wrWord = uis_pkg::uis_stat_t'(regWdata);
  assign wrEn = regWr && (regAddr == uis_pkg::OFF_EMPTY_EN);
  assign wrStat = regWr && (regAddr == uis_pkg::OFF_STATUS);
  assign vbusEdge = vbusLevel ^ vbusLevelPrev;
  // only enabled pipe flags set the summary; any pipe flag still high blocks its clear
  assign emptyRise = pipeEmptyFlags & ~prevEmptyFlags & emptyIrqEn;
  // pad enable register, reserved bits read zero
  assign enWord = {{(uis_pkg::DATA_W - PIPES){1'b0}}, emptyIrqEn};

  // status word assembly, bit 13 tied low
  always_comb begin
    statNow = '0;
    statNow.vbusChange = vbusChangeFlag;
    statNow.resume = resumeFlag;
    statNow.rsv13 = 1'b0;
    statNow.devStateChange = devStateChangeFlag;
    statNow.ctrlStageChange = ctrlStageChangeFlag;
    statNow.bufEmpty = bufEmptySummary;
    statNow.bufNotReady = bufNotReadySummary;
    statNow.bufReady = bufReadySummary;
    statNow.vbusLevel = vbusLevel;
    statNow.devState = deviceState;
    statNow.setupSeen = setupPending;
    statNow.ctrlStage = ctrlStage;
  end

  // ----------------------------------------------------------------
  // vbus pin capture
  // ----------------------------------------------------------------
  // pin is asynchronous, so it is filtered before anyone looks at it
  uis_sync3 vbusSync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .asyncIn(vbusPin),
    .syncOut(vbusLevel)
  );

  // edge detector history
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vbusLevelPrev <= 1'b0;
    end else begin
      vbusLevelPrev <= vbusLevel;
    end
  end

  // ----------------------------------------------------------------
  // enable register
  // ----------------------------------------------------------------
  // only the pipe bits are stored; the rest cannot be written
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      emptyIrqEn <= uis_pkg::EMPTY_EN_RESET[PIPES-1:0];
    end else if (evt.swReset) begin
      emptyIrqEn <= uis_pkg::EMPTY_EN_RESET[PIPES-1:0];
    end else if (wrEn) begin
      emptyIrqEn <= regWdata[PIPES-1:0];
    end
  end

  // ----------------------------------------------------------------
  // vbus change and resume flags
  // ----------------------------------------------------------------
  // with the clock stopped a written 0 keeps the clear asserted, which
  // blocks new sets until a 1 is written; the hold is the point
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      vbusChangeFlag <= 1'b0;
      vbusHold <= 1'b0;
    end else if (evt.swReset) begin
      vbusChangeFlag <= 1'b0;
      vbusHold <= 1'b0;
    end else begin
      // set beats a plain clear, but not an active hold
      if (vbusEdge && !vbusHold) begin
        vbusChangeFlag <= 1'b1;
      end else if (wrStat && !wrWord.vbusChange) begin
        vbusChangeFlag <= 1'b0;
      end
      // hold only exists while the clock is stopped
      if (intClockOn) begin
        vbusHold <= 1'b0;
      end else if (wrStat) begin
        vbusHold <= !wrWord.vbusChange;
      end
    end
  end

  // same treatment for resume
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      resumeFlag <= 1'b0;
      resumeHold <= 1'b0;
    end else if (evt.swReset) begin
      resumeFlag <= 1'b0;
      resumeHold <= 1'b0;
    end else begin
      if (evt.resumeEvt && !resumeHold) begin
        resumeFlag <= 1'b1;
      end else if (wrStat && !wrWord.resume) begin
        resumeFlag <= 1'b0;
      end
      if (intClockOn) begin
        resumeHold <= 1'b0;
      end else if (wrStat) begin
        resumeHold <= !wrWord.resume;
      end
    end
  end

  // ----------------------------------------------------------------
  // device state and its change flag
  // ----------------------------------------------------------------
  // bus reset outranks an engine-reported move in the same cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      deviceState <= uis_pkg::DEV_POWERED;
    end else if (evt.swReset) begin
      deviceState <= uis_pkg::DEV_POWERED;
    end else if (evt.busReset) begin
      deviceState <= uis_pkg::DEV_DEFAULT;
    end else if (evt.devStateEvt) begin
      deviceState <= evt.devStateNew;
    end
  end

  // clearing needs the internal clock; writing 1 does nothing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      devStateChangeFlag <= 1'b0;
    end else if (evt.swReset) begin
      devStateChangeFlag <= 1'b0;
    end else if (evt.busReset || evt.devStateEvt) begin
      devStateChangeFlag <= 1'b1;
    end else if (wrStat && intClockOn && !wrWord.devStateChange) begin
      devStateChangeFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control stage and its change flag
  // ----------------------------------------------------------------
  // field is written only by the engine
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlStage <= uis_pkg::STG_IDLE;
    end else if (evt.swReset) begin
      ctrlStage <= uis_pkg::STG_IDLE;
    end else if (evt.ctrlStageEvt) begin
      ctrlStage <= evt.ctrlStageNew;
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlStageChangeFlag <= 1'b0;
    end else if (evt.swReset) begin
      ctrlStageChangeFlag <= 1'b0;
    end else if (evt.ctrlStageEvt) begin
      ctrlStageChangeFlag <= 1'b1;
    end else if (wrStat && intClockOn && !wrWord.ctrlStageChange) begin
      ctrlStageChangeFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // setup packet flag
  // ----------------------------------------------------------------
  // other logic blocks pid writes while this is high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      setupPending <= 1'b0;
    end else if (evt.swReset) begin
      setupPending <= 1'b0;
    end else if (evt.setupEvt) begin
      setupPending <= 1'b1;
    end else if (wrStat && intClockOn && !wrWord.setupSeen) begin
      setupPending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // buffer summaries
  // ----------------------------------------------------------------
  // no write path exists into any of these
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prevEmptyFlags <= '0;
      bufEmptySummary <= 1'b0;
    end else if (evt.swReset) begin
      prevEmptyFlags <= pipeEmptyFlags;
      bufEmptySummary <= 1'b0;
    end else begin
      prevEmptyFlags <= pipeEmptyFlags;
      if (|emptyRise) begin
        bufEmptySummary <= 1'b1;
      end else if (pipeEmptyFlags == '0) begin
        bufEmptySummary <= 1'b0;
      end
    end
  end

  // requests arrive already enabled; summary tracks them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      bufNotReadySummary <= 1'b0;
      bufReadySummary <= 1'b0;
    end else if (evt.swReset) begin
      bufNotReadySummary <= 1'b0;
      bufReadySummary <= 1'b0;
    end else begin
      bufNotReadySummary <= bufNotReadyReq;
      bufReadySummary <= bufReadyReq;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // data stand for one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= uis_pkg::READ_IDLE;
    end else if (regRd) begin
      case (regAddr)
        uis_pkg::OFF_EMPTY_EN: regRdata <= enWord & uis_pkg::EMPTY_EN_MASK;
        uis_pkg::OFF_STATUS: regRdata <= statNow;
        default: regRdata <= uis_pkg::READ_IDLE; // unmapped reads zero
      endcase
    end else begin
      regRdata <= uis_pkg::READ_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_EN_RSV: assert property (
    regRd && regAddr == uis_pkg::OFF_EMPTY_EN |=> regRdata[15:7] == '0)
    else $error("enable register reserved bits not zero");

  AST_EMPTY_SET: assert property (
    (|(pipeEmptyFlags & ~prevEmptyFlags & emptyIrqEn)) && !evt.swReset
      |=> bufEmptySummary)
    else $error("enabled pipe flag did not set empty summary");

  AST_EMPTY_CAUSE: assert property (
    $rose(bufEmptySummary) |-> $past(|emptyRise))
    else $error("empty summary set without enabled pipe");

  AST_STAT_RSV: assert property (
    regRd && regAddr == uis_pkg::OFF_STATUS |=> !regRdata[13])
    else $error("status bit 13 not zero");

  AST_VBUS_CLR: assert property (
    wrStat && !regWdata[15] && !vbusEdge && !evt.swReset |=> !vbusChangeFlag)
    else $error("vbus change flag not cleared by write 0");

  AST_DEV_STATE_CHANGE_FLAG_W1: assert property (
    devStateChangeFlag && wrStat && regWdata[12] && !evt.swReset |=> devStateChangeFlag)
    else $error("state change flag cleared by write 1");

  AST_EMPTY_CLR: assert property (
    bufEmptySummary && pipeEmptyFlags != '0 && !evt.swReset |=> bufEmptySummary)
    else $error("empty summary cleared with pipe flag still set");

  AST_BUSRST: assert property (
    evt.busReset && !evt.swReset
      |=> devStateChangeFlag && deviceState == uis_pkg::DEV_DEFAULT)
    else $error("bus reset did not load default state");

  AST_SWRST: assert property (
    evt.swReset |=> !vbusChangeFlag && !resumeFlag && !setupPending
      && deviceState == uis_pkg::DEV_POWERED && ctrlStage == uis_pkg::STG_IDLE)
    else $error("software reset left status set");

  AST_SETUP: assert property (
    evt.setupEvt && !evt.swReset |=> setupPending [*1] ##1 1'b1)
    else $error("setup packet flag not set");

endmodule
`default_nettype wire

// *** uis_sync3.sv ***
`default_nettype none
// ----------------------------------------------------------------
// three-stage synchroniser with agreement filter
// ----------------------------------------------------------------
module uis_sync3 (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // asynchronous level in
  input wire logic asyncIn,
  // filtered level out
  output var logic syncOut
);

  logic stage1; // metastable catcher, read only by stage2
  logic stage2; // first settled copy
  logic stage3; // second settled copy

  // shift chain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // output moves only when the two settled copies agree
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncOut <= 1'b0;
    end else if (stage2 == stage3) begin
      syncOut <= stage3;
    end
  end

endmodule
`default_nettype wire

// *** usb_device_irq_status_test.sv ***
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench for the interrupt status block
// ----------------------------------------------------------------
module usb_device_irq_status_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic ref_clk = 1'b0; // 200 MHz
  logic rstn = 1'b0; // async, active low
  logic [uis_pkg::ADDR_W-1:0] regAddr;
  logic [uis_pkg::DATA_W-1:0] regWdata;
  logic regWr;
  logic regRd;
  logic [uis_pkg::DATA_W-1:0] regRdata;
  logic vbusPin = 1'b0; // pin starts low
  logic intClockOn = 1'b1; // internal clock supplied
  uis_pkg::uis_evt_t evt = '0; // engine pulses
  logic [6:0] pipeEmptyFlags = '0;
  logic bufNotReadyReq = 1'b0;
  logic bufReadyReq = 1'b0;
  logic setupPending;
  logic [2:0] deviceState;
  logic [2:0] ctrlStage;
  logic [15:0] rdv; // last read word
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  // ----------------------------------------------------------------
  // design and cpu model
  // ----------------------------------------------------------------
  uis_status_top u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .vbusPin(vbusPin),
    .intClockOn(intClockOn), .evt(evt), .pipeEmptyFlags(pipeEmptyFlags),
    .bufNotReadyReq(bufNotReadyReq), .bufReadyReq(bufReadyReq),
    .setupPending(setupPending), .deviceState(deviceState), .ctrlStage(ctrlStage)
  );
  uis_host_model u_host (
    .ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata)
  );

  // clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // read one register and compare the whole word
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    u_host.rd(a, rdv);
    chk(rdv, exp);
  endtask

  task automatic st(input logic [15:0] exp);
    rchk(uis_pkg::OFF_STATUS, exp);
  endtask

  // one-cycle engine pulse
  task automatic pulse(input uis_pkg::uis_evt_t e);
    @(posedge ref_clk);
    evt <= e;
    @(posedge ref_clk);
    evt <= '0;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic test_done();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    uis_pkg::uis_evt_t e;
    tick(8);
    rstn <= 1'b1;
    // reset values, bit 13 never set
    st(16'h0000);
    rchk(uis_pkg::OFF_EMPTY_EN, 16'h0000);
    // enable register keeps only bits 6..0; unmapped place reads zero
    u_host.wr(uis_pkg::OFF_EMPTY_EN, 16'hFFFF);
    rchk(uis_pkg::OFF_EMPTY_EN, 16'h007F);
    u_host.wr(8'h10, 16'hFFFF);
    rchk(8'h10, 16'h0000);
    st(16'h0000);
    // sticky flags: ones ignored, zeros clear selectively
    e = '0;
    e.resumeEvt = 1'b1;
    e.devStateEvt = 1'b1;
    e.devStateNew = uis_pkg::DEV_ADDRESS;
    e.ctrlStageEvt = 1'b1;
    e.ctrlStageNew = uis_pkg::STG_RD_DATA;
    e.setupEvt = 1'b1;
    pulse(e);
    st(16'h5829);
    chk({15'h0, setupPending}, 16'h0001);
    u_host.wr(uis_pkg::OFF_STATUS, 16'hFFFF);
    st(16'h5829);
    u_host.wr(uis_pkg::OFF_STATUS, 16'hBFFF);
    st(16'h1829);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    st(16'h0021);
    // every device state and control stage code
    for (int d = 0; d < 5; d++) begin
      e = '0;
      e.devStateEvt = 1'b1;
      e.devStateNew = d[2:0];
      pulse(e);
      u_host.rd(uis_pkg::OFF_STATUS, rdv);
      chk({13'h0, rdv[6:4]}, {13'h0, d[2:0]});
      chk({13'h0, deviceState}, {13'h0, d[2:0]});
    end
    for (int s = 0; s < 7; s++) begin
      e = '0;
      e.ctrlStageEvt = 1'b1;
      e.ctrlStageNew = s[2:0];
      pulse(e);
      u_host.rd(uis_pkg::OFF_STATUS, rdv);
      chk({13'h0, rdv[2:0]}, {13'h0, s[2:0]});
      chk({13'h0, ctrlStage}, {13'h0, s[2:0]});
    end
    // bus reset: state change flag and default state, stage untouched
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    st(16'h0046);
    e = '0;
    e.busReset = 1'b1;
    pulse(e);
    st(16'h1016);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    // empty summary: pipe 2 enabled, pipe 1 masked
    u_host.wr(uis_pkg::OFF_EMPTY_EN, 16'h0004);
    pipeEmptyFlags <= 7'h02;
    tick(2);
    st(16'h0016);
    pipeEmptyFlags <= 7'h06;
    tick(2);
    st(16'h0416);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    st(16'h0416);
    pipeEmptyFlags <= 7'h02;
    tick(2);
    st(16'h0416);
    pipeEmptyFlags <= 7'h00;
    tick(2);
    st(16'h0016);
    // ready and not-ready summaries ignore writes
    bufNotReadyReq <= 1'b1;
    bufReadyReq <= 1'b1;
    tick(2);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    st(16'h0316);
    bufNotReadyReq <= 1'b0;
    bufReadyReq <= 1'b0;
    tick(2);
    st(16'h0016);
    // vbus rise: level bit and change flag
    vbusPin <= 1'b1;
    tick(8);
    st(16'h8096);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    st(16'h0096);
    // internal clock stopped: setup not cleared, resume clear holds off sets
    intClockOn <= 1'b0;
    e = '0;
    e.setupEvt = 1'b1;
    pulse(e);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    st(16'h009E);
    // that write of zero armed the stopped-clock hold; ones release it
    u_host.wr(uis_pkg::OFF_STATUS, 16'hC000);
    e = '0;
    e.resumeEvt = 1'b1;
    pulse(e);
    st(16'h409E);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h0000);
    pulse(e);
    st(16'h009E);
    u_host.wr(uis_pkg::OFF_STATUS, 16'h4000);
    pulse(e);
    st(16'h409E);
    intClockOn <= 1'b1;
    // software reset keeps only the pin level
    e = '0;
    e.swReset = 1'b1;
    pulse(e);
    st(16'h0080);
    rchk(uis_pkg::OFF_EMPTY_EN, 16'h0000);
    chk({9'h0, deviceState, ctrlStage, setupPending}, 16'h0000);
    // hardware reset in mid-run with the pin low again
    vbusPin <= 1'b0;
    tick(8);
    u_host.wr(uis_pkg::OFF_EMPTY_EN, 16'h007F);
    rstn <= 1'b0;
    tick(3);
    chk(regRdata, 16'h0000);
    chk({9'h0, deviceState, ctrlStage, setupPending}, 16'h0000);
    rstn <= 1'b1;
    tick(8);
    st(16'h0000);
    rchk(uis_pkg::OFF_EMPTY_EN, 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
